// ===== core/egs_scaler.sv
`include "egs_consts.svh"

module egs_scaler #(
	parameter int NUM_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Command pulses from the motion controller
	input wire logic cmd_pulse,
	input wire logic cmd_dir,
	// Encoder feedback pulses
	input wire logic fb_pulse,
	input wire logic fb_dir,
	// Contacts
	input wire logic gear_step_up_input,
	input wire logic gear_step_down_input,
	input wire logic cw_travel_limit_input,
	input wire logic ccw_travel_limit_input,
	// Settings
	input wire egs_pkg::egs_ratio_s ratio [4],
	input wire logic [1:0] ratio_select,
	input wire logic gear_mode_setting,
	input wire logic limit_function_setting,
	input wire logic [30:0] following_error_range_setting,
	// Outputs
	output logic motor_pulse,
	output logic motor_dir,
	output logic position_error_alarm,
	output logic command_cleared,
	output logic signed [15:0] gear_numerator_offset
);
	import egs_pkg::*;

	localparam int N_RATIO = 4;

	// The offset arithmetic is written for a 16-bit numerator only
	if (NUM_W != 16) begin : g_bad_num_w
		$error("egs_scaler supports NUM_W of 16 only");
	end

	// Reset defaults must sit inside the ranges the logic accepts
	if (`EGS_DEN3_RESET < `EGS_DEN_MIN || `EGS_DEN4_RESET > `EGS_DEN_MAX) begin : g_bad_den
		$error("egs_scaler denominator defaults out of range");
	end
	if (`EGS_FERR_RESET > `EGS_FERR_MAX) begin : g_bad_ferr
		$error("egs_scaler following error default out of range");
	end

	// Complete block state, registered as one word
	egs_state_s st_reg;
	egs_state_s st_next;

	// Per-entry operands, one copy for each stored ratio
	wire logic signed [31:0] num_ext [N_RATIO];
	wire logic [14:0] den_ok [N_RATIO];

	// Decoded inputs
	wire logic up_rise;
	wire logic dn_rise;
	wire logic limit_act;
	wire logic clear_work;
	wire logic signed [39:0] range_s;

	// Working values of the combinational step
	logic signed [31:0] ofs_w;
	logic signed [31:0] num_sel;
	logic signed [31:0] num_eff;
	logic signed [31:0] den_eff;
	logic signed [31:0] rem_acc;
	logic signed [39:0] ferr_w;
	logic over_pos;
	logic over_neg;

	for (genvar gi = 0; gi < N_RATIO; gi++) begin : g_ratio
		assign num_ext[gi] = 32'(signed'(ratio[gi].num));
		// Pinning keeps the division from ever seeing a zero divisor
		assign den_ok[gi] = (ratio[gi].den < `EGS_DEN_MIN) ? `EGS_DEN_MIN
			: (ratio[gi].den > `EGS_DEN_MAX) ? `EGS_DEN_MAX
			: ratio[gi].den;
	end

	// The last-level flops reset low, the idle level of the contacts
	assign up_rise = gear_step_up_input && !st_reg.up_last;
	assign dn_rise = gear_step_down_input && !st_reg.dn_last;
	assign limit_act = cw_travel_limit_input || ccw_travel_limit_input;
	assign clear_work = limit_act && !limit_function_setting;
	// Signed copy of the range so a negative error compares correctly
	assign range_s = signed'(40'(following_error_range_setting));

	always_comb begin
		st_next = st_reg;
		st_next.out_pulse = 1'b0;
		// Offset steps: both edges in one cycle cancel
		ofs_w = 32'(st_reg.ofs);
		if (up_rise) begin
			ofs_w = ofs_w + `EGS_OFS_STEP;
		end
		if (dn_rise) begin
			ofs_w = ofs_w - `EGS_OFS_STEP;
		end
		if (ofs_w > `EGS_OFS_MAX) begin
			ofs_w = `EGS_OFS_MAX;
		end
		if (ofs_w < `EGS_OFS_MIN) begin
			ofs_w = `EGS_OFS_MIN;
		end

		st_next.ofs = 16'(ofs_w);
		st_next.up_last = gear_step_up_input;
		st_next.dn_last = gear_step_down_input;

		// Ratio choice
		if (gear_mode_setting) begin
			num_sel = num_ext[0] + 32'(st_reg.ofs);
			den_eff = 32'(den_ok[0]);
		end else begin
			num_sel = num_ext[ratio_select];
			den_eff = 32'(den_ok[ratio_select]);
		end
		// A negative numerator would drive backwards; it is held at zero
		if (num_sel < 0) begin
			num_eff = '0;
		end else begin
			num_eff = num_sel;
		end
		rem_acc = st_reg.rem + num_eff;

		// Pulse engine
		case (st_reg.state)
			EGS_IDLE: begin
				if (limit_act) begin
					// Commands are refused while a limit acts
					st_next.state = EGS_HOLD;
				end else if (cmd_pulse) begin
					st_next.out_dir = cmd_dir;
					if (rem_acc >= den_eff) begin
						st_next.rem = rem_acc - den_eff;
						st_next.out_pulse = 1'b1;
						st_next.state = EGS_HOLD;
					end else begin
						st_next.rem = rem_acc;
					end
				end else if (st_reg.rem >= den_eff) begin
					// Excess remainder drains one pulse at a time
					st_next.rem = st_reg.rem - den_eff;
					st_next.out_pulse = 1'b1;
					st_next.state = EGS_HOLD;
				end
			end
			EGS_HOLD: begin
				// One low cycle between motor pulses
				st_next.state = EGS_IDLE;
			end
			default: begin
				st_next.state = EGS_IDLE;
			end
		endcase

		// Setting 0 drops pending work; setting 1 keeps it but blocks commands
		if (clear_work) begin
			st_next.rem = '0;
		end
		// Cleared follows the limit contacts in either state
		st_next.cleared = limit_act;

		// Following error: scaled output minus feedback
		ferr_w = st_reg.ferr;
		if (st_reg.out_pulse) begin
			ferr_w = st_reg.out_dir ? ferr_w - 40'sd1 : ferr_w + 40'sd1;
		end
		if (fb_pulse) begin
			ferr_w = fb_dir ? ferr_w + 40'sd1 : ferr_w - 40'sd1;
		end
		if (clear_work) begin
			ferr_w = '0;
		end
		st_next.ferr = ferr_w;
		over_pos = ferr_w > range_s;
		over_neg = -ferr_w > range_s;
		// The alarm holds until reset
		st_next.alarm = st_reg.alarm || over_pos || over_neg;
	end

	always_ff @(posedge ref_clk) begin
		// Only constants here, so reset never depends on live inputs
		if (reset) begin
			st_reg.state <= EGS_IDLE;
			st_reg.ofs <= `EGS_OFS_RESET;
			st_reg.up_last <= 1'b0;
			st_reg.dn_last <= 1'b0;
			st_reg.rem <= '0;
			st_reg.ferr <= '0;
			st_reg.out_pulse <= 1'b0;
			st_reg.out_dir <= 1'b0;
			st_reg.alarm <= 1'b0;
			st_reg.cleared <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign motor_pulse = st_reg.out_pulse;
	assign motor_dir = st_reg.out_dir;
	assign position_error_alarm = st_reg.alarm;
	assign command_cleared = st_reg.cleared;
	assign gear_numerator_offset = st_reg.ofs;
endmodule : egs_scaler

// ===== pkg/egs_consts.svh
`ifndef EGS_CONSTS_SVH
`define EGS_CONSTS_SVH
`define EGS_DEN_MIN 15'd1
`define EGS_DEN_MAX 15'd30000
`define EGS_DEN3_RESET 15'd3000
`define EGS_DEN4_RESET 15'd4000
`define EGS_OFS_MIN (-32'sd30000)
`define EGS_OFS_MAX 32'sd30000
`define EGS_OFS_RESET 16'sh0000
`define EGS_OFS_STEP 32'sd1
`define EGS_MODE_RESET 1'b0
`define EGS_FERR_RESET 31'd90000
`define EGS_FERR_MAX 31'h40000000
`define EGS_LIMFN_RESET 1'b0
`endif

// ===== pkg/egs_pkg.sv
package egs_pkg;
	// One stored ratio: numerator and denominator
	typedef struct packed {
		logic [15:0] num;
		logic [14:0] den;
	} egs_ratio_s;

	typedef enum logic [1:0] {
		EGS_IDLE = 2'b01,
		EGS_HOLD = 2'b10
	} egs_state_e;

	typedef struct packed {
		egs_state_e state;
		logic signed [15:0] ofs;
		logic up_last;
		logic dn_last;
		logic signed [31:0] rem;
		logic signed [39:0] ferr;
		logic out_pulse;
		logic out_dir;
		logic alarm;
		logic cleared;
	} egs_state_s;
endpackage : egs_pkg

// ===== tb/egs_scaler_sva.sv
module egs_scaler_sva (
	// Watched ports
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic gear_step_up_input,
	input wire logic gear_step_down_input,
	input wire logic cw_travel_limit_input,
	input wire logic ccw_travel_limit_input,
	input wire logic limit_function_setting,
	input wire logic motor_pulse,
	input wire logic position_error_alarm,
	input wire logic command_cleared,
	input wire logic signed [15:0] gear_numerator_offset
);
	wire logic up = gear_step_up_input;
	wire logic dn = gear_step_down_input;
	wire logic lim = cw_travel_limit_input | ccw_travel_limit_input;
	wire logic signed [15:0] ofs = gear_numerator_offset;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	chk_step_up:
		assert property ($rose(up) && !$rose(dn) && ofs < 16'sh7530 |=> ofs == $past(ofs) + 16'sh1)
		else $error("offset step up wrong");
	chk_step_down:
		assert property ($rose(dn) && !$rose(up) && ofs > -16'sh7530 |=> ofs == $past(ofs) - 16'sh1)
		else $error("offset step down wrong");
	chk_offset_hold:
		assert property (!$rose(up) && !$rose(dn) |=> $stable(ofs))
		else $error("offset moved without edge");
	chk_offset_range:
		assert property (ofs <= 16'sh7530 && ofs >= -16'sh7530)
		else $error("offset out of range");
	chk_alarm_sticky:
		assert property (position_error_alarm |=> position_error_alarm)
		else $error("alarm dropped");
	chk_pulse_once:
		assert property (motor_pulse |=> !motor_pulse)
		else $error("motor pulse too long");
	chk_limit_clear:
		assert property (lim |=> command_cleared)
		else $error("limit did not clear");
	chk_clear_release:
		assert property (!lim |=> !command_cleared)
		else $error("clear held without limit");
	chk_reset_state:
		assert property ($past(reset) |-> !motor_pulse && !position_error_alarm && ofs == 16'sh0)
		else $error("outputs not cleared");
	cover property ($rose(up));
	cover property (motor_pulse);
	cover property (position_error_alarm);
	cover property (lim && limit_function_setting);
endmodule : egs_scaler_sva

bind egs_scaler egs_scaler_sva chk_u (.*);

// ===== tb/egs_cmd_src.sv
module egs_cmd_src (
	// Clock and request
	input wire logic ref_clk,
	input wire logic go,
	input wire logic dir,
	// Command to the scaler
	output logic cmd_pulse,
	output logic cmd_dir
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ph_reg = 2'h0;
	initial cmd_pulse = 1'h0;
	initial cmd_dir = 1'h0;
	// Spacing of four clears the hold cycle after each output pulse
	always @(posedge ref_clk) begin
		cmd_pulse <= #1 go && ph_reg == 2'h0;
		cmd_dir <= #1 dir;
		ph_reg <= go ? ph_reg + 2'h1 : 2'h0;
	end
endmodule : egs_cmd_src

// ===== tb/egs_scaler_bench.sv
module egs_scaler_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, reset = 1, go = 0, fb_en = 1, fb = 0, up = 0, dn = 0, cw = 0, mode = 0;
	logic cmd_pulse, cmd_dir, mp, alarm, clr, mdir;
	logic dir = 0, lf = 0, fbd = 0;
	logic [1:0] sel = 2'h3;
	logic [30:0] range = 31'h15f90;
	logic signed [15:0] ofs;
	egs_pkg::egs_ratio_s ratio [4];
	int n_errors = 0, comparisons = 0, n_pulse = 0;
	always #12.5 ref_clk = ~ref_clk;
	// Feedback trails the output so following error stays near zero
	always @(posedge ref_clk) begin
		fb <= #1 mp & fb_en;
		fbd <= #1 mdir;
		if (mp === 1'b1)
			n_pulse++;
	end
	egs_cmd_src src_u (.ref_clk, .go, .dir, .cmd_pulse, .cmd_dir);
	egs_scaler dut_u (.ref_clk, .reset, .cmd_pulse, .cmd_dir, .fb_pulse(fb), .fb_dir(fbd),
		.gear_step_up_input(up), .gear_step_down_input(dn), .cw_travel_limit_input(cw),
		.ccw_travel_limit_input(1'h0), .ratio, .ratio_select(sel), .gear_mode_setting(mode),
		.limit_function_setting(lf), .following_error_range_setting(range),
		.motor_pulse(mp), .motor_dir(mdir), .position_error_alarm(alarm),
		.command_cleared(clr), .gear_numerator_offset(ofs));
	task chk(string s, int e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s exp %0d got %0d", s, e, g);
		end
	endtask : chk
	task step(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task run(int n);
		n_pulse = 0;
		go = 1;
		step(4 * n);
		go = 0;
		step(20);
	endtask : run
	task tog(bit u);
		if (u)
			up = 1;
		else
			dn = 1;
		step(2);
		up = 0;
		dn = 0;
		step(2);
	endtask : tog
	task close_out;
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task t_stored(logic [1:0] s, int n);
		sel = s;
		run(n);
		chk("pulses", n * ratio[s].num / ratio[s].den, n_pulse);
	endtask : t_stored
	task t_offset;
		tog(1);
		tog(1);
		tog(1);
		tog(0);
		chk("offset", 2, ofs);
		mode = 1;
		run(40);
		chk("pulses", 80 / ratio[0].den, n_pulse);
		mode = 0;
	endtask : t_offset
	task t_limit(bit f);
		lf = f;
		sel = 2'h3;
		run(2);
		cw = 1;
		step(2);
		chk("cleared", 1, clr);
		run(10);
		chk("pulses", 0, n_pulse);
		cw = 0;
		step(2);
		chk("cleared", 0, clr);
		run(2);
		chk("pulses", f, n_pulse);
		lf = 0;
	endtask : t_limit
	task t_alarm;
		fb_en = 0;
		range = 31'h5;
		sel = 2'h1;
		go = 1;
		for (int i = 0; i < 200 && alarm !== 1'b1; i++)
			step(1);
		go = 0;
		if (alarm !== 1'b1) begin
			n_errors++;
			close_out;
		end
		step(20);
		chk("alarm", 1, alarm);
		reset = 1;
		step(2);
		reset = 0;
		step(1);
		chk("alarm", 0, alarm);
	endtask : t_alarm
	initial begin
		ratio[0] = '{16'h0000, 15'h0008};
		ratio[1] = '{16'h0064, 15'h0064};
		ratio[2] = '{16'h05dc, 15'h0bb8};
		ratio[3] = '{16'h03e8, 15'h0fa0};
		step(6);
		reset = 0;
		step(1);
		chk("offset", 0, ofs);
		t_stored(2'h3, 40);
		t_stored(2'h2, 20);
		dir = 1;
		t_stored(2'h3, 8);
		chk("dir", 1, mdir);
		dir = 0;
		t_offset;
		t_limit(1);
		t_limit(0);
		t_alarm;
		close_out;
	end
endmodule : egs_scaler_bench
